// *** timer_pkg.sv ***
`default_nettype none
package timer_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int COUNT_WIDTH = 16;
    localparam int N_COMPARE = 3;
    localparam int N_CAPTURE = 2;
    localparam int ADDR_WIDTH = 5;

    // ------------------------------------------------------------
    // Byte addresses on the core bus
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL_STATUS = 5'h08;
    localparam logic [4:0] ADDR_COUNT_HI = 5'h09;
    localparam logic [4:0] ADDR_COUNT_LO = 5'h0a;
    localparam logic [4:0] ADDR_ALIAS_HI = 5'h15;
    localparam logic [4:0] ADDR_ALIAS_LO = 5'h16;
    localparam logic [4:0] ADDR_PIN_CONTROL = 5'h17;
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h18;
    localparam logic [4:0] ADDR_FLAGS = 5'h19;
    localparam logic [2:0][4:0] ADDR_COMPARE_HI = {5'h1c, 5'h1a, 5'h0b};
    localparam logic [2:0][4:0] ADDR_COMPARE_LO = {5'h1d, 5'h1b, 5'h0c};
    localparam logic [1:0][4:0] ADDR_CAPTURE_HI = {5'h1e, 5'h0d};
    localparam logic [1:0][4:0] ADDR_CAPTURE_LO = {5'h1f, 5'h0e};

    // ------------------------------------------------------------
    // Field positions of the combined register (write side)
    // ------------------------------------------------------------
    localparam int CCS_LEVEL_1 = 0;
    localparam int CCS_EDGE_1 = 1;
    localparam int CCS_OVF_EN = 2;
    localparam int CCS_MATCH_EN_1 = 3;
    localparam int CCS_CAPTURE_EN_1 = 4;
    // Pin control register: levels, edges, drive enables
    localparam int PCR_LEVEL_LSB = 0;
    localparam int PCR_EDGE_LSB = 3;
    localparam int PCR_DRIVE_LSB = 5;
    // Irq enable register
    localparam int IER_OVF_EN = 2;
    localparam int IER_MATCH_LSB = 3;
    localparam int IER_CAPTURE_LSB = 6;

    // ------------------------------------------------------------
    // Reset and preset values
    // ------------------------------------------------------------
    localparam logic [15:0] COMPARE_RESET = 16'hffff;
    localparam logic [15:0] COUNT_PRESET = 16'hfff8;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [2:0] DRIVE_EN_RESET = 3'h1;
    localparam logic [1:0] ONES_LOW_BITS = 2'h3;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage
`default_nettype wire

// *** timer_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface timer_bus_if;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic [7:0] rdata;
    logic ack;

    // Core side issues one-cycle strobes, timer answers with ack
    modport core_end (output addr, output wdata, output rd, output wr,
                      input rdata, input ack);
    modport timer_end (input addr, input wdata, input rd, input wr,
                       output rdata, output ack);
endinterface
`default_nettype wire

// *** capture_edge.sv ***
`timescale 1ns/100ps
`default_nettype none
module capture_edge
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Pin and selection
    input wire logic pin_i,
    input wire logic rising_i,
    // Capture request
    output logic fire_o
);
    typedef struct packed {
        logic now;
        logic last;
        logic fire;
    } edge_state_t;

    edge_state_t s;
    edge_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.now = pin_i;
        next_s.last = s.now;
        // Fire lands one cycle after the edge is seen, the second E edge
        next_s.fire = rising_i ? (s.now & ~s.last) : (~s.now & s.last);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            s <= '0;
        end
        else if (ce_i)
        begin
            s <= next_s;
        end
    end

    assign fire_o = s.fire;
endmodule
`default_nettype wire

// *** timer_core.sv ***
// Summary of operation
// - Counter steps each E cycle; test preset.
// - Overflow flag set at all ones.
// - Alias counter read never clears overflow.
// - Three compare registers checked every cycle.
// - Match sets flag, copies output level.
// - Match level on pin only with enable and direction.
// - High-byte write skips one compare; bytes independent.
// - Level copied on every match.
// - Compare registers reset to all ones.
// - Two captures store counter on chosen edge.
// - Capture lands third E edge after transition.
// - Capture ignores flag, keeps newest value.
// - No capture inside a two-byte capture read.
// - Source holds pulses two E cycles minimum.
// - Combined register readable, bits 0-4 writable.
// - Edge select 1 resets low; 1 rising.
// - Level bit and output register 1 reset low.
// - Enabled flags raise shared timer interrupt.
// - Overflow cleared by status then count-high read.
// - Match flag 1 cleared by status then write.
// - Capture flag 1 cleared by status then read.
// - Drive enable 1 resets high; selects pin source.
`timescale 1ns/100ps
`default_nettype none
module timer_core
#(
    parameter int COUNT_WIDTH = timer_pkg::COUNT_WIDTH
)
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Core bus
    timer_bus_if.timer_end bus,
    // Test mode 0 strap level
    input wire logic test_mode_i,
    // Capture pins: bit 0 is capture_pin_1, bit 1 capture_pin_2
    input wire logic [1:0] capture_pin_i,
    // Port direction and data bits behind the compare pins
    input wire logic [2:0] port_dir_i,
    input wire logic [2:0] port_data_i,
    // Compare pins: bit 0 is compare_pin_1
    output logic [2:0] compare_pin_o,
    output logic [2:0] compare_pin_oe_o,
    // Interrupt
    output logic timer_interrupt_line_o
);
    localparam int NC = timer_pkg::N_COMPARE;
    localparam int NK = timer_pkg::N_CAPTURE;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // The byte split of every 16-bit register assumes this width
    if (COUNT_WIDTH != timer_pkg::COUNT_WIDTH)
    begin : width_check
        $error("timer_core: COUNT_WIDTH must be 16");
    end

    typedef struct packed {
        logic [15:0] count;
        logic [7:0] count_low;
        logic [NC-1:0][15:0] compare;
        logic [NC-1:0] inhibit;
        logic [NC-1:0] out_level;
        logic [NC-1:0] match_output_level;
        logic [NC-1:0] pin_drive_enable;
        logic [NC-1:0] match_flag;
        logic [NC-1:0] match_arm;
        logic [NC-1:0] match_irq_enable;
        logic [NK-1:0][15:0] capture;
        logic [NK-1:0] capture_lock;
        logic [NK-1:0] capture_flag;
        logic [NK-1:0] capture_arm;
        logic [NK-1:0] capture_irq_enable;
        logic [NK-1:0] edge_select;
        logic overflow_flag;
        logic overflow_arm;
        logic overflow_irq_enable;
        logic [7:0] rdata;
        logic ack;
        logic irq;
        logic [NC-1:0] pin;
        logic [NC-1:0] pin_oe;
    } timer_state_t;

    timer_state_t s;
    timer_state_t next_s;
    logic [NK-1:0] fire;

    // ------------------------------------------------------------
    // Edge detectors
    // ------------------------------------------------------------
    // Pins are watched whatever their direction
    for (genvar k = 0; k < NK; k++)
    begin : capture_ch
        capture_edge edge_det (
            .clock_i(clock_i),
            .reset_i(reset_i),
            .ce_i(ce_i),
            .pin_i(capture_pin_i[k]),
            .rising_i(s.edge_select[k]),
            .fire_o(fire[k])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [NC-1:0] match_set;
        logic [NK-1:0] capture_set;
        logic overflow_set;
        logic status_read;
        logic flags_read;
        logic [7:0] rv;
        next_s = s;
        match_set = '0;
        capture_set = '0;
        overflow_set = &s.count;
        status_read = bus.rd && (bus.addr == timer_pkg::ADDR_CTRL_STATUS);
        flags_read = bus.rd && (bus.addr == timer_pkg::ADDR_FLAGS);
        rv = timer_pkg::UNMAPPED_READ;
        next_s.ack = bus.rd | bus.wr;
        next_s.count = s.count + timer_pkg::COUNT_STEP;
        next_s.inhibit = '0;

        for (int i = 0; i < NC; i++)
        begin
            // Compare against the counter value of this E cycle
            if (s.count == s.compare[i] && !s.inhibit[i])
            begin
                match_set[i] = 1'b1;
                next_s.out_level[i] = s.match_output_level[i];
            end
        end

        for (int k = 0; k < NK; k++)
        begin
            // A pending flag does not stop a newer capture
            if (fire[k] && !s.capture_lock[k])
            begin
                next_s.capture[k] = s.count;
                capture_set[k] = 1'b1;
            end
        end

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (bus.wr)
        begin
            case (bus.addr)
                timer_pkg::ADDR_CTRL_STATUS:
                begin
                    // Flag bits 5..7 are read only
                    next_s.match_output_level[0] = bus.wdata[timer_pkg::CCS_LEVEL_1];
                    next_s.edge_select[0] = bus.wdata[timer_pkg::CCS_EDGE_1];
                    next_s.overflow_irq_enable = bus.wdata[timer_pkg::CCS_OVF_EN];
                    next_s.match_irq_enable[0] = bus.wdata[timer_pkg::CCS_MATCH_EN_1];
                    next_s.capture_irq_enable[0] = bus.wdata[timer_pkg::CCS_CAPTURE_EN_1];
                end
                timer_pkg::ADDR_COUNT_HI:
                begin
                    if (test_mode_i)
                    begin
                        next_s.count = timer_pkg::COUNT_PRESET;
                    end
                end
                timer_pkg::ADDR_PIN_CONTROL:
                begin
                    next_s.match_output_level = bus.wdata[timer_pkg::PCR_LEVEL_LSB +: NC];
                    next_s.edge_select = bus.wdata[timer_pkg::PCR_EDGE_LSB +: NK];
                    next_s.pin_drive_enable = bus.wdata[timer_pkg::PCR_DRIVE_LSB +: NC];
                end
                timer_pkg::ADDR_IRQ_ENABLE:
                begin
                    next_s.overflow_irq_enable = bus.wdata[timer_pkg::IER_OVF_EN];
                    next_s.match_irq_enable = bus.wdata[timer_pkg::IER_MATCH_LSB +: NC];
                    next_s.capture_irq_enable = bus.wdata[timer_pkg::IER_CAPTURE_LSB +: NK];
                end
                default:
                begin
                end
            endcase
            for (int i = 0; i < NC; i++)
            begin
                if (bus.addr == timer_pkg::ADDR_COMPARE_HI[i])
                begin
                    next_s.compare[i][15:8] = bus.wdata;
                    next_s.inhibit[i] = 1'b1;
                end
                if (bus.addr == timer_pkg::ADDR_COMPARE_LO[i])
                begin
                    next_s.compare[i][7:0] = bus.wdata;
                end
                if ((bus.addr == timer_pkg::ADDR_COMPARE_HI[i] ||
                     bus.addr == timer_pkg::ADDR_COMPARE_LO[i]) && s.match_arm[i])
                begin
                    next_s.match_flag[i] = 1'b0;
                    next_s.match_arm[i] = 1'b0;
                end
            end
        end

        // --------------------------------------------------------
        // Register reads and their side effects
        // --------------------------------------------------------
        if (bus.rd)
        begin
            case (bus.addr)
                timer_pkg::ADDR_CTRL_STATUS:
                    rv = {s.capture_flag[0], s.match_flag[0], s.overflow_flag,
                          s.capture_irq_enable[0], s.match_irq_enable[0],
                          s.overflow_irq_enable, s.edge_select[0],
                          s.match_output_level[0]};
                timer_pkg::ADDR_COUNT_HI:
                begin
                    rv = s.count[15:8];
                    next_s.count_low = s.count[7:0];
                    if (s.overflow_arm)
                    begin
                        next_s.overflow_flag = 1'b0;
                        next_s.overflow_arm = 1'b0;
                    end
                end
                timer_pkg::ADDR_ALIAS_HI:
                begin
                    rv = s.count[15:8];
                    next_s.count_low = s.count[7:0];
                end
                timer_pkg::ADDR_COUNT_LO, timer_pkg::ADDR_ALIAS_LO:
                    rv = s.count_low;
                timer_pkg::ADDR_PIN_CONTROL:
                    rv = {s.pin_drive_enable, s.edge_select, s.match_output_level};
                timer_pkg::ADDR_IRQ_ENABLE:
                    rv = {s.capture_irq_enable, s.match_irq_enable,
                          s.overflow_irq_enable, timer_pkg::ONES_LOW_BITS};
                timer_pkg::ADDR_FLAGS:
                    rv = {s.capture_flag, s.match_flag, s.overflow_flag,
                          timer_pkg::ONES_LOW_BITS};
                default:
                begin
                end
            endcase
            for (int i = 0; i < NC; i++)
            begin
                if (bus.addr == timer_pkg::ADDR_COMPARE_HI[i])
                begin
                    rv = s.compare[i][15:8];
                end
                if (bus.addr == timer_pkg::ADDR_COMPARE_LO[i])
                begin
                    rv = s.compare[i][7:0];
                end
            end
            for (int k = 0; k < NK; k++)
            begin
                if (bus.addr == timer_pkg::ADDR_CAPTURE_HI[k])
                begin
                    rv = s.capture[k][15:8];
                    // Held until the low byte is read
                    next_s.capture_lock[k] = 1'b1;
                    if (s.capture_arm[k])
                    begin
                        next_s.capture_flag[k] = 1'b0;
                        next_s.capture_arm[k] = 1'b0;
                    end
                end
                if (bus.addr == timer_pkg::ADDR_CAPTURE_LO[k])
                begin
                    rv = s.capture[k][7:0];
                    next_s.capture_lock[k] = 1'b0;
                end
            end
            next_s.rdata = rv;
        end

        // --------------------------------------------------------
        // Arming and setting of flags; a set beats a clear
        // --------------------------------------------------------
        // Overflow and channel 1 flags arm from either status view, the others from the flag view
        if (status_read || flags_read)
        begin
            next_s.overflow_arm = s.overflow_flag;
            next_s.match_arm[0] = s.match_flag[0];
            next_s.capture_arm[0] = s.capture_flag[0];
        end
        if (flags_read)
        begin
            next_s.match_arm = s.match_flag;
            next_s.capture_arm = s.capture_flag;
        end
        next_s.overflow_flag = next_s.overflow_flag | overflow_set;
        next_s.match_flag = next_s.match_flag | match_set;
        next_s.capture_flag = next_s.capture_flag | capture_set;

        next_s.irq = (next_s.overflow_flag & next_s.overflow_irq_enable) |
                     (|(next_s.match_flag & next_s.match_irq_enable)) |
                     (|(next_s.capture_flag & next_s.capture_irq_enable));
        for (int i = 0; i < NC; i++)
        begin
            next_s.pin[i] = next_s.pin_drive_enable[i] ? next_s.out_level[i]
                                                       : port_data_i[i];
            next_s.pin[i] = next_s.pin[i] & port_dir_i[i];
            next_s.pin_oe[i] = port_dir_i[i];
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            s <= '0;
            s.compare <= {NC{timer_pkg::COMPARE_RESET}};
            s.pin_drive_enable <= timer_pkg::DRIVE_EN_RESET;
        end
        else if (ce_i)
        begin
            s <= next_s;
        end
    end

    assign bus.rdata = s.rdata;
    assign bus.ack = s.ack;
    assign compare_pin_o = s.pin;
    assign compare_pin_oe_o = s.pin_oe;
    assign timer_interrupt_line_o = s.irq;
endmodule
`default_nettype wire

// *** core_bridge.sv ***
`timescale 1ns/100ps
`default_nettype none
module core_bridge
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Avalon-MM slave
    input wire logic [6:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Timer bus
    timer_bus_if.core_end bus
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10
    } bridge_state_t;

    typedef struct packed {
        bridge_state_t state;
        logic [4:0] addr;
        logic [7:0] wdata;
        logic rd;
        logic wr;
        logic [31:0] readdata;
        logic waitrequest;
    } bridge_t;

    bridge_t s;
    bridge_t next_s;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Each Avalon word maps to one timer byte; the upper bits read as zero
    always_comb
    begin
        next_s = s;
        // Strobes last one cycle only
        next_s.rd = 1'b0;
        next_s.wr = 1'b0;
        case (s.state)
            ST_IDLE:
            begin
                if (read_i || write_i)
                begin
                    next_s.addr = address_i[6:2];
                    next_s.wdata = writedata_i[7:0];
                    next_s.rd = read_i;
                    // A write without lane 0 still completes, with no effect
                    next_s.wr = write_i & byteenable_i[0];
                    next_s.state = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (bus.ack || !s.rd && !s.wr)
                begin
                    next_s.readdata = {24'h00_0000, bus.rdata};
                    next_s.state = ST_DONE;
                end
            end
            ST_DONE:
            begin
                next_s.state = ST_IDLE;
            end
            default:
            begin
                next_s.state = ST_IDLE;
            end
        endcase
        next_s.waitrequest = (next_s.state != ST_DONE);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            s <= '0;
            s.state <= ST_IDLE;
            s.waitrequest <= 1'b1;
        end
        else if (ce_i)
        begin
            s <= next_s;
        end
    end

    assign bus.addr = s.addr;
    assign bus.wdata = s.wdata;
    assign bus.rd = s.rd;
    assign bus.wr = s.wr;
    assign readdata_o = s.readdata;
    assign waitrequest_o = s.waitrequest;
endmodule
`default_nettype wire

// *** placeholder_none.sv ***
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** timer_bus_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module timer_bus_sva
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Timer bus
    input wire logic [4:0] addr,
    input wire logic rd,
    input wire logic wr,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_ack_follows_strobe: assert property ((rd || wr) |=> ack)
        else $error("strobe without ack");
    a_ack_one_cycle: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (ack |-> $past(rd) || $past(wr))
        else $error("ack without strobe");
    a_no_read_write: assert property (!(rd && wr))
        else $error("read and write together");
    a_strobe_spaced: assert property ((rd || wr) |=> !(rd || wr))
        else $error("strobes back to back");
    a_rdata_holds: assert property (!ack |-> $stable(rdata))
        else $error("read data moved without ack");
    a_unmapped_zero: assert property (rd && addr == 5'h00 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flag_low_ones: assert property (rd && addr == timer_pkg::ADDR_FLAGS |=> rdata[1:0] == 2'h3)
        else $error("flag register low bits not ones");
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic test_mode_i = 1'b0;
    logic [1:0] capture_pin_i = 2'h3;
    logic [2:0] port_dir_i = 3'h1;
    logic [2:0] port_data_i = 3'h0;
    logic [6:0] address_i = 7'h00;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0000_0000;
    logic [31:0] readdata_o;
    logic waitrequest_o;
    logic [2:0] compare_pin_o;
    logic [2:0] compare_pin_oe_o;
    logic timer_interrupt_line_o;
    logic [20:0] exp_q[$];
    logic [20:0] ent;
    logic [7:0] rdq;
    logic [7:0] hi;
    logic [15:0] c;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t;
    timer_bus_if bus();
    core_bridge u_core_bridge (.clock_i(clock_i), .reset_i(reset_i), .ce_i(1'b1),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .byteenable_i(4'h1), .readdata_o(readdata_o),
        .waitrequest_o(waitrequest_o), .bus(bus));
    timer_core u_timer_core (.clock_i(clock_i), .reset_i(reset_i), .ce_i(1'b1), .bus(bus),
        .test_mode_i(test_mode_i), .capture_pin_i(capture_pin_i), .port_dir_i(port_dir_i),
        .port_data_i(port_data_i), .compare_pin_o(compare_pin_o),
        .compare_pin_oe_o(compare_pin_oe_o), .timer_interrupt_line_o(timer_interrupt_line_o));
    timer_bus_sva u_timer_bus_sva (.clock_i(clock_i), .reset_i(reset_i), .addr(bus.addr),
        .rd(bus.rd), .wr(bus.wr), .rdata(bus.rdata), .ack(bus.ack));
    initial
    begin
        forever #12.5 clock_i = ~clock_i;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk_pin(input string name, input logic e, input logic g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s exp %b seen %b", name, e, g);
        end
    endtask
    task automatic chk_byte(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m,
                            input logic [7:0] g);
        cmp_count++;
        if ((g & m) !== (e & m))
        begin
            n_errors++;
            $display("[FAIL] reg %h exp %h seen %h", a, e & m, g & m);
        end
    endtask
    // Holds the request until waitrequest is sampled low, as the bus requires
    task automatic bus_cycle(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clock_i);
        address_i <= {a, 2'h0};
        write_i <= w;
        read_i <= !w;
        writedata_i <= {24'h00_0000, d};
        do
        begin
            @(posedge clock_i);
        end
        while (waitrequest_o !== 1'b0);
        rdq = readdata_o[7:0];
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({a, e, m});
        bus_cycle(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus_cycle(1'b1, a, d);
    endtask
    // ----------------------------------------
    // Result watcher, cycle count, watchdog
    // ----------------------------------------
    always @(posedge clock_i)
    begin
        cyc <= reset_i ? 0 : cyc + 1;
        if (read_i && waitrequest_o === 1'b0 && exp_q.size() > 0)
        begin
            ent = exp_q.pop_front();
            chk_byte(ent[20:16], ent[15:8], ent[7:0], readdata_o[7:0]);
        end
    end
    initial
    begin
        repeat (20000) @(posedge clock_i);
        n_errors++;
        close_out();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h37c8_f367));
        repeat (5) @(posedge clock_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            rd(timer_pkg::ADDR_COMPARE_HI[i], 8'hff, 8'hff);
            rd(timer_pkg::ADDR_COMPARE_LO[i], 8'hff, 8'hff);
        end
        rd(timer_pkg::ADDR_CTRL_STATUS, 8'h00, 8'hff);
        rd(timer_pkg::ADDR_PIN_CONTROL, 8'h20, 8'hff);
        rd(timer_pkg::ADDR_IRQ_ENABLE, 8'h03, 8'hff);
        rd(5'h00, 8'h00, 8'hff);
        wr(timer_pkg::ADDR_CTRL_STATUS, 8'hff);
        rd(timer_pkg::ADDR_CTRL_STATUS, 8'h1f, 8'hff);
        chk_pin("irq idle", 1'b0, timer_interrupt_line_o);
        $display("test reset_and_access done");
        port_data_i <= 3'($urandom());
        wr(timer_pkg::ADDR_PIN_CONTROL, 8'h00);
        repeat (3) @(posedge clock_i);
        chk_pin("pin data path", port_data_i[0], compare_pin_o[0]);
        port_dir_i <= 3'h0;
        repeat (3) @(posedge clock_i);
        chk_pin("pin enable", 1'b0, compare_pin_oe_o[0]);
        port_dir_i <= 3'h1;
        wr(timer_pkg::ADDR_PIN_CONTROL, 8'h20);
        $display("test pin_mux done");
        wr(timer_pkg::ADDR_CTRL_STATUS, 8'h09);
        rd(timer_pkg::ADDR_COUNT_HI, 8'h00, 8'h00);
        hi = rdq;
        rd(timer_pkg::ADDR_COUNT_LO, 8'h00, 8'h00);
        c = {hi, rdq} + 16'h0064;
        wr(timer_pkg::ADDR_COMPARE_HI[0], c[15:8]);
        wr(timer_pkg::ADDR_COMPARE_LO[0], c[7:0]);
        chk_pin("level before match", 1'b0, compare_pin_o[0]);
        repeat (150) @(posedge clock_i);
        chk_pin("level after match", 1'b1, compare_pin_o[0]);
        chk_pin("irq on match", 1'b1, timer_interrupt_line_o);
        rd(timer_pkg::ADDR_CTRL_STATUS, 8'h49, 8'hff);
        wr(timer_pkg::ADDR_COMPARE_LO[0], c[7:0]);
        rd(timer_pkg::ADDR_CTRL_STATUS, 8'h09, 8'hff);
        chk_pin("irq cleared", 1'b0, timer_interrupt_line_o);
        $display("test compare done");
        for (int e = 0; e < 2; e++)
        begin
            wr(timer_pkg::ADDR_CTRL_STATUS, 8'(e << 1));
            capture_pin_i[0] <= (e == 0);
            repeat (4) @(posedge clock_i);
            capture_pin_i[0] <= (e == 1);
            t = cyc;
            repeat (6) @(posedge clock_i);
            rd(timer_pkg::ADDR_CTRL_STATUS, 8'h80 | 8'(e << 1), 8'h83);
            rd(timer_pkg::ADDR_CAPTURE_HI[0], 8'h00, 8'h00);
            hi = rdq;
            rd(timer_pkg::ADDR_CAPTURE_LO[0], 8'h00, 8'h00);
            c = {hi, rdq} - 16'(t);
            chk_pin("capture delay", 1'b1, c inside {[16'h0002:16'h0004]});
            rd(timer_pkg::ADDR_CTRL_STATUS, 8'h00, 8'h80);
        end
        $display("test capture done");
        test_mode_i <= 1'b1;
        wr(timer_pkg::ADDR_COUNT_HI, 8'h00);
        test_mode_i <= 1'b0;
        rd(timer_pkg::ADDR_ALIAS_HI, 8'hff, 8'hff);
        repeat (20) @(posedge clock_i);
        rd(timer_pkg::ADDR_CTRL_STATUS, 8'h20, 8'h20);
        rd(timer_pkg::ADDR_ALIAS_HI, 8'h00, 8'h00);
        rd(timer_pkg::ADDR_CTRL_STATUS, 8'h20, 8'h20);
        rd(timer_pkg::ADDR_COUNT_HI, 8'h00, 8'h00);
        rd(timer_pkg::ADDR_CTRL_STATUS, 8'h00, 8'h20);
        rd(timer_pkg::ADDR_FLAGS, 8'h33, 8'hf7);
        $display("test overflow done");
        close_out();
    end
endmodule
`default_nettype wire
